/* design/stpg_guard.sv */
// Per-port time-out discard and end-to-end dword parity guard.
// Assumes one core clock, a register port from the switch core, and queues
// that pop their head in the cycle headDrop is high.
`timescale 1ns/1ps
`default_nettype none
`include "stpg_defines.svh"

// Contract
// - Drop a queue-head packet older than 64 seconds.
// - Discard by age applies to posted, non-posted, completion and inserted packets.
// - Discard active after reset; control bit turns it off.
// - Each discard sets the status bit of the packet's type.
// - Each discard bumps a per-type saturating counter; a read clears it.
// - Per-type report field picks message; enables mask it.
// - One message per status rise; none again until cleared and set.
// - Reset policy: posted and inserted nonfatal; others unreported.
// - Time-out during broadcast aborts that packet.
// - Ingress checks link CRC and computes dword even parity.
// - Parity updated incrementally on changes, never regenerated.
// - Egress checks parity alongside outgoing link CRC.
// - Parity error nullifies packet: inverted CRC, ended bad; partner discards.
// - Parity error sets status bit and bumps read-clear saturating counter.
// - Packet memories keep dword parity; errors flow to end-to-end check.
// - Parity report field; message on status rise only.
// - Disable bit stops parity checking; generation always on.
// - Inject bit and matching length invert parity of every dword.
// - Non-matching lengths keep correct parity while injecting.
// - After reset, checking on and errors reported nonfatal.
// - Self-made packets get parity while generated.
// - Consumed packets are checked; bad ones discarded and reported.
module stpg_guard #(
	parameter int unsigned TICK_CYCLES = `STPG_TICK_CYCLES,
	parameter int unsigned CNT_W = 8
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic reset_n,
	// Register port
	input wire logic [`STPG_ADDR_W-1:0] regAddr,
	input wire logic [31:0] regWrData,
	input wire logic regWrite,
	input wire logic regRead,
	output logic [31:0] regRdData,
	// Ingress queue head
	input wire logic headValid,
	input wire stpg_pkg::stpg_tlp_e headType,
	input wire logic [7:0] headStamp,
	input wire logic headBroadcast,
	output logic [7:0] nowSeconds,
	output logic headDrop,
	output logic headAbort,
	// Ingress data link dwords
	input wire logic inValid,
	input wire logic [31:0] inData,
	input wire logic [`STPG_LEN_W-1:0] inLen,
	input wire logic inLast,
	input wire logic inCrcOk,
	output logic inOutValid,
	output logic [31:0] inOutData,
	output logic inOutPar,
	output logic inRetry,
	// Self-generated dwords
	input wire logic genValid,
	input wire logic [31:0] genData,
	output logic genPar,
	// In-switch dword modification
	input wire logic modValid,
	input wire logic [31:0] modOldData,
	input wire logic [31:0] modNewData,
	input wire logic modOldPar,
	output logic modNewPar,
	// Egress data link dwords
	input wire logic egValid,
	input wire logic [31:0] egData,
	input wire logic egPar,
	input wire logic egLast,
	input wire logic [31:0] egLcrc,
	output logic egOutValid,
	output logic [31:0] egOutData,
	output logic egOutLast,
	output logic [31:0] egOutLcrc,
	output logic egOutNullify,
	// Consumed dwords
	input wire logic conValid,
	input wire logic [31:0] conData,
	input wire logic conPar,
	input wire logic conLast,
	output logic conDiscard,
	// Error messages
	output logic msgValid,
	output stpg_pkg::stpg_report_e msgKind
);
	import stpg_pkg::*;
	default clocking cbSys @(posedge clk_sys); endclocking
	default disable iff (!reset_n);

	localparam int unsigned TICK_W = $clog2(TICK_CYCLES + 1);
	localparam logic [CNT_W-1:0] CNT_MAX = '1;
	if (TICK_CYCLES < 1 || CNT_W < 1 || CNT_W > 8) begin : g_bad_params
		$error("stpg_guard: unsupported parameter values");
	end
	function automatic logic evenPar(input logic [31:0] d);
		return ^d;
	endfunction

	function automatic logic [CNT_W-1:0] satNext(input logic [CNT_W-1:0] cur, input logic inc,
			input logic clr);
		if (clr) begin
			return inc ? CNT_W'(1) : '0;
		end else if (inc && cur != CNT_MAX) begin
			return cur + CNT_W'(1);
		end
		return cur;
	endfunction

	function automatic logic allowed(input stpg_report_e k, input logic [4:0] en);
		case (k)
			RPT_COR: return en[`STPG_ERR_EN_COR];
			RPT_NONFATAL: return en[`STPG_ERR_EN_NF] | en[`STPG_ERR_EN_SERR];
			RPT_FATAL: return en[`STPG_ERR_EN_FATAL] | en[`STPG_ERR_EN_SERR];
			default: return 1'b0;
		endcase
	endfunction

	// Software state
	logic toDisable;
	logic [3:0] toStatus;
	logic [CNT_W-1:0] toCount [4];
	logic [7:0] toReport;
	logic parDisable;
	logic parInject;
	logic [`STPG_LEN_W-1:0] parLen;
	logic parStatus;
	logic [CNT_W-1:0] parCount;
	logic [1:0] parReport;
	logic [4:0] errEnable;

	logic wrHit [9];
	logic rdHit [9];
	always_comb begin
		for (int i = 0; i < 9; i++) begin
			wrHit[i] = regWrite && regAddr == `STPG_ADDR_W'(`STPG_OFF_TO_CTL + 4 * i);
			rdHit[i] = regRead && regAddr == `STPG_ADDR_W'(`STPG_OFF_TO_CTL + 4 * i);
		end
	end
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			toDisable <= 1'b0;
			toReport <= `STPG_TO_RPT_RESET;
			parDisable <= 1'b0;
			parInject <= 1'b0;
			parLen <= '0;
			parReport <= `STPG_PAR_RPT_RESET;
			errEnable <= '0;
		end else begin
			if (wrHit[0]) begin
				toDisable <= regWrData[0];
			end
			if (wrHit[3]) begin
				toReport <= regWrData[7:0];
			end
			if (wrHit[4]) begin
				parDisable <= regWrData[`STPG_PAR_CTL_DIS];
				parInject <= regWrData[`STPG_PAR_CTL_INJ];
				parLen <= regWrData[`STPG_PAR_CTL_LEN_LO +: `STPG_LEN_W];
			end
			if (wrHit[7]) begin
				parReport <= regWrData[1:0];
			end
			if (wrHit[8]) begin
				errEnable <= regWrData[4:0];
			end
		end
	end

	// Seconds time base for age stamps
	logic [TICK_W-1:0] tickCnt;
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			tickCnt <= '0;
			nowSeconds <= '0;
		end else if (tickCnt == TICK_W'(TICK_CYCLES - 1)) begin
			tickCnt <= '0;
			nowSeconds <= nowSeconds + 8'h01;
		end else begin
			tickCnt <= tickCnt + TICK_W'(1);
		end
	end

	// Age discard at queue head
	logic [7:0] headAge;
	logic dropNow;
	logic [3:0] toSet;
	assign headAge = nowSeconds - headStamp;
	assign dropNow = headValid && !toDisable && !headDrop
			&& headAge > 8'(`STPG_AGE_LIMIT_S);
	always_comb begin
		toSet = '0;
		toSet[headType] = dropNow;
	end

	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			headDrop <= 1'b0;
			headAbort <= 1'b0;
		end else begin
			headDrop <= dropNow;
			headAbort <= dropNow && headBroadcast;
		end
	end

	// Ingress parity generation with test injection
	logic injectHit;
	assign injectHit = parInject && inLen == parLen;
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			inOutValid <= 1'b0;
			inOutData <= '0;
			inOutPar <= 1'b0;
			inRetry <= 1'b0;
			genPar <= 1'b0;
			modNewPar <= 1'b0;
		end else begin
			inOutValid <= inValid;
			inOutData <= inData;
			inOutPar <= evenPar(inData) ^ injectHit;
			inRetry <= inValid && inLast && !inCrcOk;
			if (genValid) begin
				genPar <= evenPar(genData);
			end
			if (modValid) begin
				modNewPar <= modOldPar ^ evenPar(modOldData) ^ evenPar(modNewData);
			end
		end
	end

	// Egress check and nullify; memory parity errors arrive here unchanged
	logic egBad;
	logic egPktErr;
	logic egPktBad;
	assign egBad = egValid && !parDisable && (egPar != evenPar(egData));
	assign egPktBad = egValid && egLast && (egPktErr || egBad);
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			egPktErr <= 1'b0;
			egOutValid <= 1'b0;
			egOutData <= '0;
			egOutLast <= 1'b0;
			egOutLcrc <= '0;
			egOutNullify <= 1'b0;
		end else begin
			egPktErr <= egValid ? (!egLast && (egPktErr || egBad)) : egPktErr;
			egOutValid <= egValid;
			egOutData <= egData;
			egOutLast <= egValid && egLast;
			egOutLcrc <= egPktBad ? ~egLcrc : egLcrc;
			egOutNullify <= egPktBad;
		end
	end

	// Consumed packet check
	logic conBad;
	logic conPktErr;
	logic conPktBad;
	assign conBad = conValid && !parDisable && (conPar != evenPar(conData));
	assign conPktBad = conValid && conLast && (conPktErr || conBad);
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			conPktErr <= 1'b0;
			conDiscard <= 1'b0;
		end else begin
			conPktErr <= conValid ? (!conLast && (conPktErr || conBad)) : conPktErr;
			conDiscard <= conPktBad;
		end
	end

	// Status, counters and message raising
	logic parSet;
	logic [3:0] toClr;
	logic parClr;
	logic [4:0] rise;
	assign parSet = egPktBad || conPktBad;
	assign toClr = wrHit[1] ? regWrData[3:0] : 4'h0;
	assign parClr = wrHit[5] && regWrData[0];
	assign rise[3:0] = toSet & ~(toStatus & ~toClr);
	assign rise[4] = parSet && !(parStatus && !parClr);

	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			toStatus <= '0;
			parStatus <= 1'b0;
			parCount <= '0;
			for (int i = 0; i < 4; i++) begin
				toCount[i] <= '0;
			end
		end else begin
			toStatus <= (toStatus & ~toClr) | toSet;
			parStatus <= (parStatus && !parClr) || parSet;
			parCount <= satNext(parCount, parSet, rdHit[6]);
			for (int i = 0; i < 4; i++) begin
				toCount[i] <= satNext(toCount[i], toSet[i], rdHit[2]);
			end
		end
	end

	logic [4:0] pend;
	logic [4:0] next_pend;
	logic [4:0] grant;
	stpg_report_e kindOf [5];
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			kindOf[i] = stpg_report_e'(toReport[2*i +: 2]);
		end
		kindOf[4] = stpg_report_e'(parReport);
		grant = '0;
		for (int i = 4; i >= 0; i--) begin
			if (pend[i]) begin
				grant = 5'h0;
				grant[i] = 1'b1;
			end
		end
		next_pend = pend & ~grant;
		for (int i = 0; i < 5; i++) begin
			if (rise[i] && allowed(kindOf[i], errEnable)) begin
				next_pend[i] = 1'b1;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			pend <= '0;
			msgValid <= 1'b0;
			msgKind <= RPT_NONE;
		end else begin
			pend <= next_pend;
			msgValid <= |grant;
			msgKind <= RPT_NONE;
			for (int i = 0; i < 5; i++) begin
				if (grant[i]) begin
					msgKind <= kindOf[i];
				end
			end
		end
	end

	// Read data, valid only in the cycle after the strobe
	always_ff @(posedge clk_sys) begin
		if (!reset_n || !regRead) begin
			regRdData <= '0;
		end else begin
			case (regAddr)
				`STPG_OFF_TO_CTL: regRdData <= {31'h0, toDisable};
				`STPG_OFF_TO_STS: regRdData <= {28'h0, toStatus};
				`STPG_OFF_TO_CNT: regRdData <= {8'(toCount[3]), 8'(toCount[2]), 8'(toCount[1]),
						8'(toCount[0])};
				`STPG_OFF_TO_RPT: regRdData <= {24'h0, toReport};
				`STPG_OFF_PAR_CTL: regRdData <= {6'h0, parLen, 14'h0, parInject, parDisable};
				`STPG_OFF_PAR_STS: regRdData <= {31'h0, parStatus};
				`STPG_OFF_PAR_CNT: regRdData <= {24'h0, 8'(parCount)};
				`STPG_OFF_PAR_RPT: regRdData <= {30'h0, parReport};
				`STPG_OFF_ERR_EN: regRdData <= {27'h0, errEnable};
				default: regRdData <= 32'h0;
			endcase
		end
	end
	// Checks
	sequence s_parFault;
		egValid && egLast && !parDisable && (egPar != evenPar(egData)) && !egPktErr;
	endsequence
	a_old_head_drop: assert property (headValid && !toDisable && !headDrop
		&& headAge > 8'd64 |=> headDrop) else $error("old head not dropped");
	a_young_head_kept: assert property (headDrop |-> $past(headAge) > 8'd64
		&& !$past(toDisable)) else $error("head dropped too young or while disabled");
	a_bcast_abort: assert property (headAbort |-> headDrop && $past(headBroadcast))
		else $error("abort without broadcast drop");
	a_drop_status: assert property (dropNow |=> toStatus[$past(headType)])
		else $error("drop left status clear");
	a_null_crc: assert property (s_parFault |=> egOutNullify && parStatus
		&& egOutLcrc == ~$past(egLcrc)) else $error("bad parity not nullified");
	a_good_crc: assert property (egValid && egLast && !egPktErr && !egBad
		|=> !egOutNullify && egOutLcrc == $past(egLcrc)) else $error("good packet altered");
	a_inject_par: assert property (inValid && parInject && inLen == parLen
		|=> inOutPar != evenPar(inOutData)) else $error("inject did not invert parity");
	a_clean_par: assert property (inValid && !(parInject && inLen == parLen)
		|=> inOutPar == evenPar(inOutData)) else $error("parity wrong without inject");
	a_count_clear: assert property (rdHit[6] && !parSet |=> parCount == '0)
		else $error("parity count not cleared by read");
	a_count_sat: assert property (parCount == CNT_MAX && !rdHit[6]
		|=> parCount == CNT_MAX) else $error("counter left saturation");
	a_one_msg: assert property (toStatus[0] && !toClr[0]
		|=> !pend[0] || $past(pend[0])) else $error("message raised on set status");
	a_consume_drop: assert property (conValid && conLast && !parDisable
		&& conPar != evenPar(conData) |=> conDiscard && parStatus)
		else $error("bad consumed packet kept");
endmodule
`default_nettype wire

/* design/stpg_defines.svh */
// Offsets, field positions, reset values and timing counts of the guard.
// Included by the guard module only; definitions only.
`ifndef STPG_DEFINES_SVH
`define STPG_DEFINES_SVH

`define STPG_ADDR_W 8
`define STPG_OFF_TO_CTL 8'h00
`define STPG_OFF_TO_STS 8'h04
`define STPG_OFF_TO_CNT 8'h08
`define STPG_OFF_TO_RPT 8'h0c
`define STPG_OFF_PAR_CTL 8'h10
`define STPG_OFF_PAR_STS 8'h14
`define STPG_OFF_PAR_CNT 8'h18
`define STPG_OFF_PAR_RPT 8'h1c
`define STPG_OFF_ERR_EN 8'h20

`define STPG_PAR_CTL_DIS 0
`define STPG_PAR_CTL_INJ 1
`define STPG_PAR_CTL_LEN_LO 16
`define STPG_LEN_W 10

`define STPG_ERR_EN_SERR 0
`define STPG_ERR_EN_COR 1
`define STPG_ERR_EN_NF 2
`define STPG_ERR_EN_FATAL 3
`define STPG_ERR_EN_UR 4

`define STPG_TO_RPT_RESET 8'h82
`define STPG_PAR_RPT_RESET 2'h2

`define STPG_AGE_LIMIT_S 64
`define STPG_CLK_HZ 250000000
`define STPG_TICK_CYCLES (`STPG_CLK_HZ * 1)

`endif

/* design/stpg_pkg.sv */
// Types shared by the time-out and parity guard.
// Assumes nothing of its surroundings.
package stpg_pkg;
	typedef enum logic [1:0] {TLP_POSTED, TLP_NONPOSTED, TLP_COMPLETION, TLP_INSERTED} stpg_tlp_e;
	typedef enum logic [1:0] {RPT_NONE, RPT_COR, RPT_NONFATAL, RPT_FATAL} stpg_report_e;
endpackage

/* testbench/stpg_link_partner.sv */
// Link partner model: takes the guard's egress packets.
// Assumes one beat per cycle with a last marker.
`timescale 1ns/1ps
`default_nettype none
module stpg_link_partner (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic reset_n,
	// Egress link
	input wire logic egOutValid,
	input wire logic egOutLast,
	input wire logic egOutNullify,
	// Tallies
	output logic [7:0] goodPkts,
	output logic [7:0] droppedPkts
);
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			goodPkts <= 8'h00;
			droppedPkts <= 8'h00;
		end else if (egOutValid && egOutLast) begin
			if (egOutNullify) begin
				droppedPkts <= droppedPkts + 8'h01;
			end else begin
				goodPkts <= goodPkts + 8'h01;
			end
		end
	end
endmodule
`default_nettype wire

/* testbench/stpg_guard_test.sv */
// Self-checking bench for the time-out and parity guard.
// Assumes the guard and the link partner model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module stpg_guard_test;
	import stpg_pkg::*;
	logic clk_sys = 1'b0;
	logic reset_n = 1'b0;
	logic regWrite = 1'b0, regRead = 1'b0, headValid = 1'b0, headBroadcast = 1'b0;
	logic inValid = 1'b0, inLast = 1'b0, inCrcOk = 1'b0, genValid = 1'b0, modValid = 1'b0;
	logic modOldPar = 1'b0, egValid = 1'b0, egPar = 1'b0, egLast = 1'b0;
	logic conValid = 1'b0, conPar = 1'b0, conLast = 1'b0;
	logic [7:0] regAddr = 8'h00, headStamp = 8'h00;
	logic [9:0] inLen = 10'h000;
	logic [31:0] regWrData = 32'h0, inData = 32'h0, genData = 32'h0, modOldData = 32'h0;
	logic [31:0] modNewData = 32'h0, egData = 32'h0, egLcrc = 32'h0, conData = 32'h0;
	stpg_tlp_e headType = TLP_POSTED;
	logic [31:0] regRdData, inOutData, egOutData, egOutLcrc, rv;
	logic [7:0] nowSeconds, goodPkts, droppedPkts;
	logic headDrop, headAbort, inOutValid, inOutPar, inRetry, genPar, modNewPar;
	logic egOutValid, egOutLast, egOutNullify, conDiscard, msgValid;
	stpg_report_e msgKind;
	stpg_report_e msgLast = RPT_NONE;
	int errTotal = 0, comparisons = 0, msgCnt = 0;

	stpg_guard #(.TICK_CYCLES(4)) i_dut (
		.clk_sys, .reset_n, .regAddr, .regWrData, .regWrite, .regRead, .regRdData,
		.headValid, .headType, .headStamp, .headBroadcast, .nowSeconds, .headDrop,
		.headAbort, .inValid, .inData, .inLen, .inLast, .inCrcOk, .inOutValid,
		.inOutData, .inOutPar, .inRetry, .genValid, .genData, .genPar, .modValid,
		.modOldData, .modNewData, .modOldPar, .modNewPar, .egValid, .egData, .egPar,
		.egLast, .egLcrc, .egOutValid, .egOutData, .egOutLast, .egOutLcrc,
		.egOutNullify, .conValid, .conData, .conPar, .conLast, .conDiscard,
		.msgValid, .msgKind
	);
	stpg_link_partner i_partner (
		.clk_sys, .reset_n, .egOutValid, .egOutLast, .egOutNullify, .goodPkts, .droppedPkts
	);

	always #2 clk_sys = ~clk_sys;
	always @(posedge clk_sys) begin
		if (msgValid === 1'b1) begin
			msgCnt <= msgCnt + 1;
			msgLast <= msgKind;
		end
	end

	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			errTotal++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		regAddr <= a;
		regWrData <= d;
		regWrite <= 1'b1;
		@(posedge clk_sys);
		regWrite <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge clk_sys);
		regAddr <= a;
		regRead <= 1'b1;
		@(posedge clk_sys);
		regRead <= 1'b0;
		#1;
		rv = regRdData;
	endtask
	task automatic inDw(input logic [31:0] d, input logic [9:0] len, input logic crc,
		input logic par, input logic retry);
		@(posedge clk_sys);
		inValid <= 1'b1;
		inData <= d;
		inLen <= len;
		inLast <= 1'b1;
		inCrcOk <= crc;
		@(posedge clk_sys);
		inValid <= 1'b0;
		#1;
		chk("inOutData", inOutData, d);
		chk("inOutPar", inOutPar, par);
		chk("inRetry", inRetry, retry);
		chk("inOutValid", inOutValid, 1'b1);
	endtask
	task automatic egPkt(input logic bad, input logic expNull);
		@(posedge clk_sys);
		egValid <= 1'b1;
		egData <= 32'h1234_5678;
		egPar <= ^32'h1234_5678;
		@(posedge clk_sys);
		egData <= 32'h0f0f_00ff;
		egPar <= bad ^ (^32'h0f0f_00ff);
		egLast <= 1'b1;
		egLcrc <= 32'hc0de_0001;
		@(posedge clk_sys);
		egValid <= 1'b0;
		egLast <= 1'b0;
		#1;
		chk("egOutLast", egOutLast, 1'b1);
		chk("egOutValid", egOutValid, 1'b1);
		chk("egOutData", egOutData, 32'h0f0f_00ff);
		chk("egOutNullify", egOutNullify, expNull);
		chk("egOutLcrc", egOutLcrc, expNull ? 32'h3f21_fffe : 32'hc0de_0001);
	endtask
	task automatic conPkt(input logic bad);
		@(posedge clk_sys);
		conValid <= 1'b1;
		conData <= 32'h0000_0101;
		conPar <= bad;
		conLast <= 1'b1;
		@(posedge clk_sys);
		conValid <= 1'b0;
		#1;
		chk("conDiscard", conDiscard, bad);
	endtask
	task automatic headTry(input logic [1:0] t, input logic [7:0] age, input logic bc,
		input logic exp);
		logic [7:0] p;
		p = nowSeconds;
		for (int i = 0; i < 12 && nowSeconds === p; i++) begin
			@(posedge clk_sys);
			#1;
		end
		@(posedge clk_sys);
		headValid <= 1'b1;
		headType <= stpg_tlp_e'(t);
		headStamp <= nowSeconds - age;
		headBroadcast <= bc;
		@(posedge clk_sys);
		#1;
		chk("headDrop", headDrop, exp);
		chk("headAbort", headAbort, exp & bc);
		@(posedge clk_sys);
		headValid <= 1'b0;
	endtask

	task automatic testReset();
		logic [7:0] p;
		rd(8'h00);
		chk("toCtl", rv, 32'h0);
		rd(8'h0c);
		chk("toRpt", rv, 32'h82);
		rd(8'h10);
		chk("parCtl", rv, 32'h0);
		rd(8'h1c);
		chk("parRpt", rv, 32'h2);
		wr(8'h3c, 32'hffff_ffff);
		rd(8'h3c);
		chk("unmapped", rv, 32'h0);
		p = nowSeconds;
		tick(4);
		#1;
		chk("nowSeconds", nowSeconds, 8'(p + 8'h01));
		$display("done reset");
	endtask
	task automatic testIngress();
		inDw(32'h0000_0001, 10'd5, 1'b1, 1'b1, 1'b0);
		inDw(32'h0000_0003, 10'd5, 1'b0, 1'b0, 1'b1);
		wr(8'h10, 32'h0005_0002);
		inDw(32'h0000_0003, 10'd5, 1'b1, 1'b1, 1'b0);
		inDw(32'h0000_0003, 10'd6, 1'b1, 1'b0, 1'b0);
		wr(8'h10, 32'h0);
		@(posedge clk_sys);
		genValid <= 1'b1;
		genData <= 32'h0000_0007;
		modValid <= 1'b1;
		modOldData <= 32'h0000_0003;
		modNewData <= 32'h8000_0000;
		modOldPar <= 1'b1;
		@(posedge clk_sys);
		genValid <= 1'b0;
		modValid <= 1'b0;
		#1;
		chk("genPar", genPar, 1'b1);
		chk("modNewPar", modNewPar, 1'b0);
		$display("done ingress");
	endtask
	task automatic testParity();
		int m;
		egPkt(1'b0, 1'b0);
		tick(1);
		#1;
		chk("goodPkts", goodPkts, 8'h01);
		wr(8'h20, 32'h4);
		m = msgCnt;
		egPkt(1'b1, 1'b1);
		egPkt(1'b1, 1'b1);
		tick(3);
		chk("droppedPkts", droppedPkts, 8'h02);
		chk("msgCnt", msgCnt, m + 1);
		chk("msgKind", msgLast, RPT_NONFATAL);
		rd(8'h14);
		chk("parSts", rv, 32'h1);
		rd(8'h18);
		chk("parCnt", rv, 32'h2);
		rd(8'h18);
		chk("parCnt", rv, 32'h0);
		wr(8'h14, 32'h1);
		conPkt(1'b0);
		conPkt(1'b1);
		tick(3);
		chk("msgCnt", msgCnt, m + 2);
		rd(8'h18);
		chk("parCnt", rv, 32'h1);
		wr(8'h10, 32'h1);
		egPkt(1'b1, 1'b0);
		inDw(32'h0000_0003, 10'd1, 1'b1, 1'b0, 1'b0);
		wr(8'h10, 32'h0);
		$display("done parity");
	endtask
	task automatic testTimeout();
		int m;
		m = msgCnt;
		for (int t = 0; t < 4; t++) headTry(t[1:0], 8'd65, 1'b0, 1'b1);
		tick(3);
		rd(8'h04);
		chk("toSts", rv, 32'hf);
		rd(8'h08);
		chk("toCnt", rv, 32'h0101_0101);
		rd(8'h08);
		chk("toCnt", rv, 32'h0);
		chk("msgCnt", msgCnt, m + 2);
		headTry(2'd0, 8'd65, 1'b0, 1'b1);
		tick(3);
		chk("msgCnt", msgCnt, m + 2);
		wr(8'h04, 32'h1);
		headTry(2'd0, 8'd65, 1'b0, 1'b1);
		tick(3);
		chk("msgCnt", msgCnt, m + 3);
		headTry(2'd0, 8'd64, 1'b0, 1'b0);
		headTry(2'd3, 8'd65, 1'b1, 1'b1);
		wr(8'h00, 32'h1);
		headTry(2'd0, 8'd65, 1'b0, 1'b0);
		wr(8'h00, 32'h0);
		m = msgCnt;
		for (int k = 1; k < 4; k++) begin
			wr(8'h0c, k);
			wr(8'h20, 32'h1 << k);
			wr(8'h04, 32'hf);
			headTry(2'd0, 8'd65, 1'b0, 1'b1);
			tick(3);
			chk("msgCnt", msgCnt, m + k);
			chk("msgKind", msgLast, k);
		end
		wr(8'h20, 32'h0);
		wr(8'h04, 32'hf);
		headTry(2'd0, 8'd65, 1'b0, 1'b1);
		tick(3);
		chk("msgCnt", msgCnt, m + 3);
		$display("done timeout");
	endtask
	task automatic testSaturate();
		rd(8'h08);
		@(posedge clk_sys);
		headType <= TLP_POSTED;
		headStamp <= nowSeconds - 8'd100;
		headValid <= 1'b1;
		tick(600);
		headValid <= 1'b0;
		tick(2);
		rd(8'h08);
		chk("toCnt", rv, 32'h0000_00ff);
		rd(8'h08);
		chk("toCnt", rv, 32'h0);
		$display("done saturate");
	endtask
	task automatic wrapUp();
		$display("comparisons %0d mismatches %0d", comparisons, errTotal);
		if (errTotal == 0 && comparisons > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	initial begin
		repeat (2) @(posedge clk_sys);
		reset_n <= 1'b1;
		testReset();
		testIngress();
		testParity();
		testTimeout();
		testSaturate();
		wrapUp();
	end
	initial begin
		repeat (20000) @(posedge clk_sys);
		errTotal++;
		wrapUp();
	end
endmodule
`default_nettype wire
